/* src/led_sink_device.sv */
module led_sink_device
  import led_sink_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  led_link_if.device                  link_if,
  output logic [LATCH_W-1:0]          sink_outputs_out,
  output logic [LATCH_W*BC_W-1:0]     sink_level_out,
  output logic [BC_W-1:0]             red_brightness_out,
  output logic [BC_W-1:0]             green_brightness_out,
  output logic [BC_W-1:0]             blue_brightness_out,
  output logic [DET_W-1:0]            detect_code_out,
  output logic                        open_led_check_out,
  output logic                        shorted_led_check_out,
  output logic                        onoff_loaded_out,
  output logic                        control_loaded_out,
  output logic [WORD_W-1:0]           shift_word_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] pins_raw;
  logic [PIN_N-1:0] meta_r;
  logic [PIN_N-1:0] sync_r;

  assign pins_raw[PIN_SCLK]  = link_if.shift_clock;
  assign pins_raw[PIN_SDATA] = link_if.serial_data;
  assign pins_raw[PIN_XFER]  = link_if.transfer_pulse;
  assign pins_raw[PIN_BLANK] = link_if.blank;

  // Pins come from the controller, not from our clock
  generate
    for (genvar p = 0; p < PIN_N; p++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          meta_r[p] <= 1'b0;
          sync_r[p] <= 1'b0;
        end else begin
          meta_r[p] <= pins_raw[p];
          sync_r[p] <= meta_r[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_prev_r;
  logic xfer_prev_r;
  logic shift_rise;
  logic xfer_rise;
  logic blank_now;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sclk_prev_r <= 1'b0;
      xfer_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sync_r[PIN_SCLK];
      xfer_prev_r <= sync_r[PIN_XFER];
    end
  end

  // Edges are found on the synchronised copies, so a clock phase
  // shorter than one cycle can slip between samples
  assign shift_rise = sync_r[PIN_SCLK] & ~sclk_prev_r;
  assign xfer_rise  = sync_r[PIN_XFER] & ~xfer_prev_r;
  // Blank counts as asserted during reset so nothing lights early
  assign blank_now  = sync_r[PIN_BLANK] | rst_in;

  // ----------------------------------------------------------------
  // Common shift register
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word;

  // Data and clock share the synchroniser delay, so the bit seen at
  // the clock edge is the one the controller set up before it
  // Extra clocks push the oldest bits out of the top; the last 25
  // bits before a pulse form the word
  common_shift common_shift_i (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .shift_in (shift_rise),
    .bit_in   (sync_r[PIN_SDATA]),
    .word_out (word)
  );

  assign shift_word_out = word;

  // ----------------------------------------------------------------
  // Data latches
  // ----------------------------------------------------------------
  logic [LATCH_W-1:0] output_enable_bits_r;
  logic [LATCH_W-1:0] group_control_word_r;
  logic               onoff_loaded_r;
  logic               control_loaded_r;

  // Only the latch picked by the top bit moves; the other holds
  // Real latches power up undefined; here they clear on reset so the
  // model starts from a known state. Software must not rely on it.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      output_enable_bits_r <= LATCH_RESET;
    end else if (xfer_rise && word[SEL_BIT] == SEL_ONOFF) begin
      output_enable_bits_r <= word[LATCH_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      group_control_word_r <= LATCH_RESET;
    end else if (xfer_rise && word[SEL_BIT] == SEL_CONTROL) begin
      group_control_word_r <= word[LATCH_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      onoff_loaded_r   <= 1'b0;
      control_loaded_r <= 1'b0;
    end else begin
      onoff_loaded_r   <= xfer_rise & (word[SEL_BIT] == SEL_ONOFF);
      control_loaded_r <= xfer_rise & (word[SEL_BIT] == SEL_CONTROL);
    end
  end

  // One-cycle strobes marking a load; they carry no data
  assign onoff_loaded_out   = onoff_loaded_r;
  assign control_loaded_out = control_loaded_r;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  logic [BC_W-1:0] group_brightness [GROUP_N];

  assign group_brightness[0] = group_control_word_r[RED_LSB +: BC_W];
  assign group_brightness[1] = group_control_word_r[GREEN_LSB +: BC_W];
  assign group_brightness[2] = group_control_word_r[BLUE_LSB +: BC_W];

  // Brightness reaches the outputs straight from the latch, with no
  // further event needed
  assign red_brightness_out   = group_brightness[0];
  assign green_brightness_out = group_brightness[1];
  assign blue_brightness_out  = group_brightness[2];

  // Detection select is only passed out; no detection is modelled
  assign detect_code_out = group_control_word_r[DET_LSB +: DET_W];
  // Codes 0-3 open check, 4-7 shorted check
  assign shorted_led_check_out =
    group_control_word_r[DET_SHORT_BIT];
  assign open_led_check_out =
    ~group_control_word_r[DET_SHORT_BIT];

  // ----------------------------------------------------------------
  // Sink outputs
  // ----------------------------------------------------------------
  logic [LATCH_W-1:0]      sink_r;
  logic [LATCH_W*BC_W-1:0] level_r;

  generate
    for (genvar ch = 0; ch < LATCH_W; ch++) begin : g_sink
      localparam int GRP = ch / GROUP_SIZE;
      // Blank and latch are sampled every clock, so a change shows
      // one cycle after it reaches these flops
      always_ff @(posedge clock_in) begin
        if (blank_now) begin
          sink_r[ch] <= 1'b0;
        end else begin
          sink_r[ch] <= output_enable_bits_r[ch];
        end
      end

      // Off channels carry a zero code so no stale level is seen
      always_ff @(posedge clock_in) begin
        if (blank_now || !output_enable_bits_r[ch]) begin
          level_r[ch*BC_W +: BC_W] <= BC_OFF;
        end else begin
          level_r[ch*BC_W +: BC_W] <= group_brightness[GRP];
        end
      end
    end
  endgenerate

  assign sink_outputs_out = sink_r;
  assign sink_level_out   = level_r;

endmodule : led_sink_device

/* inc/led_sink_pkg.sv */
package led_sink_pkg;

  // ----------------------------------------------------------------
  // Word and latch layout
  // ----------------------------------------------------------------
  localparam int WORD_W        = 25;
  localparam int LATCH_W       = 24;
  localparam int SEL_BIT       = 24;
  localparam int GROUP_SIZE    = 8;
  localparam int GROUP_N       = 3;
  localparam int BC_W          = 7;
  localparam int RED_LSB       = 0;
  localparam int GREEN_LSB     = 7;
  localparam int BLUE_LSB      = 14;
  localparam int DET_LSB       = 21;
  localparam int DET_W         = 3;
  localparam int DET_SHORT_BIT = 23;

  localparam logic SEL_ONOFF   = 1'b0;
  localparam logic SEL_CONTROL = 1'b1;

  localparam logic [WORD_W-1:0]  WORD_RESET  = 25'h0000000;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 24'h000000;
  localparam logic [BC_W-1:0]    BC_OFF      = 7'h00;

  // ----------------------------------------------------------------
  // Pin sampling in the device
  // ----------------------------------------------------------------
  localparam int PIN_N     = 4;
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_XFER  = 2;
  localparam int PIN_BLANK = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALF_BIT_NS   = 32;
  // Least time: round up, at least one cycle
  localparam int HALF_BIT_CYC_RAW =
    (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_BIT_CYC =
    (HALF_BIT_CYC_RAW < 1) ? 1 : HALF_BIT_CYC_RAW;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] HALF_LAST =
    CNT_W'(HALF_BIT_CYC - 1);
  localparam logic [4:0] BIT_TOP = 5'(WORD_W - 1);

endpackage : led_sink_pkg

/* inc/led_link_if.sv */
interface led_link_if;
  logic shift_clock;
  logic serial_data;
  logic transfer_pulse;
  logic blank;

  modport device (
    input shift_clock,
    input serial_data,
    input transfer_pulse,
    input blank
  );

  modport host (
    output shift_clock,
    output serial_data,
    output transfer_pulse,
    output blank
  );
endinterface : led_link_if

/* src/common_shift.sv */
module common_shift
  import led_sink_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              shift_in,
  input  wire logic              bit_in,
  output logic [WORD_W-1:0]      word_out
);

  // ----------------------------------------------------------------
  // Serial word, first bit ends at the top
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      word_out <= WORD_RESET;
    end else if (shift_in) begin
      word_out <= {word_out[WORD_W-2:0], bit_in};
    end
  end

endmodule : common_shift

/* src/led_sink_host.sv */
module led_sink_host
  import led_sink_pkg::*;
(
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire logic                write_valid_in,
  input  wire logic                write_select_in,
  input  wire logic [LATCH_W-1:0]  write_data_in,
  input  wire logic                blank_in,
  output logic                     write_ready_out,
  led_link_if.host                 link_if
);

  // ----------------------------------------------------------------
  // Word sender
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOW   = 2'b01,
    ST_HIGH  = 2'b10,
    ST_PULSE = 2'b11
  } send_state_e;

  send_state_e        state_r;
  logic [WORD_W-1:0]  word_r;
  logic [4:0]         bit_r;
  logic [CNT_W-1:0]   cnt_r;
  logic               sclk_r;
  logic               sdata_r;
  logic               xfer_r;
  logic               blank_r;

  assign write_ready_out = (state_r == ST_IDLE);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      word_r  <= WORD_RESET;
      bit_r   <= 5'h00;
      cnt_r   <= '0;
      sclk_r  <= 1'b0;
      sdata_r <= 1'b0;
      xfer_r  <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (write_valid_in) begin
            word_r  <= {write_select_in, write_data_in};
            sdata_r <= write_select_in;
            bit_r   <= BIT_TOP;
            cnt_r   <= '0;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_r == HALF_LAST) begin
            cnt_r   <= '0;
            sclk_r  <= 1'b1;
            state_r <= ST_HIGH;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt_r == HALF_LAST) begin
            cnt_r  <= '0;
            sclk_r <= 1'b0;
            if (bit_r == 5'h00) begin
              xfer_r  <= 1'b1;
              state_r <= ST_PULSE;
            end else begin
              bit_r   <= bit_r - 1'b1;
              sdata_r <= word_r[bit_r - 1'b1];
              state_r <= ST_LOW;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_PULSE: begin
          if (cnt_r == HALF_LAST) begin
            cnt_r   <= '0;
            xfer_r  <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Blanking
  // ----------------------------------------------------------------
  // Held high through reset: latches are unknown until loaded
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      blank_r <= 1'b1;
    end else begin
      blank_r <= blank_in;
    end
  end

  assign link_if.shift_clock    = sclk_r;
  assign link_if.serial_data    = sdata_r;
  assign link_if.transfer_pulse = xfer_r;
  assign link_if.blank          = blank_r;

endmodule : led_sink_host

/* verification/led_link_properties.sv */
module led_link_properties
  import led_sink_pkg::*;
(
  input wire logic               clock_in,
  input wire logic               rst_in,
  input wire logic               shift_clock,
  input wire logic               serial_data,
  input wire logic               transfer_pulse,
  input wire logic               blank,
  input wire logic [LATCH_W-1:0] sink_outputs_out,
  input wire logic [WORD_W-1:0]  shift_word_out,
  input wire logic               onoff_loaded_out,
  input wire logic               control_loaded_out
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Wire framing
  // ----------------------------------------------------------------
  a_pulse_width: assert property (
    $rose(transfer_pulse) |-> transfer_pulse [*4] ##1 !transfer_pulse)
    else $error("transfer pulse width wrong");
  a_pulse_sclk_low: assert property (
    transfer_pulse |-> !shift_clock)
    else $error("shift clock high during transfer pulse");
  a_sclk_high_width: assert property (
    $rose(shift_clock) |-> shift_clock [*4] ##1 !shift_clock)
    else $error("shift clock high phase wrong");
  a_data_held_high: assert property (
    shift_clock |-> $stable(serial_data))
    else $error("serial data moved while shift clock high");

  // ----------------------------------------------------------------
  // Device reaction
  // ----------------------------------------------------------------
  a_bit_enters_low: assert property (
    $rose(shift_clock) |-> ##3 shift_word_out[0] == $past(serial_data, 3))
    else $error("shifted bit not at bottom of word");
  a_onoff_select: assert property (
    $rose(transfer_pulse) && !shift_word_out[SEL_BIT]
      |-> ##3 onoff_loaded_out && !control_loaded_out)
    else $error("on/off latch not loaded");
  a_control_select: assert property (
    $rose(transfer_pulse) && shift_word_out[SEL_BIT]
      |-> ##3 control_loaded_out && !onoff_loaded_out)
    else $error("control latch not loaded");
  a_load_needs_pulse: assert property (
    onoff_loaded_out || control_loaded_out
      |-> $past(transfer_pulse, 3) && !$past(transfer_pulse, 4))
    else $error("latch loaded without transfer pulse");
  a_blank_forces_off: assert property (
    blank [*4] |-> sink_outputs_out == '0)
    else $error("sinks on while blanked");
  a_sinks_follow: assert property (
    onoff_loaded_out && !blank && !$past(blank) && !$past(blank, 2)
      && !$past(blank, 3)
      |=> sink_outputs_out == $past(shift_word_out[LATCH_W-1:0]))
    else $error("sinks differ from loaded word");

  c_onoff: cover property (onoff_loaded_out && !blank);
  c_control: cover property (control_loaded_out);
  c_blank: cover property (blank [*4] ##1 !blank);
endmodule : led_link_properties

/* verification/test_led_sink_onoff_latch_select.sv */
module test_led_sink_onoff_latch_select
  import led_sink_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clock_in, rst_in, blank_in;
  logic                      write_valid_in, write_select_in;
  logic [LATCH_W-1:0]        write_data_in, sink_outputs_out;
  logic                      write_ready_out;
  logic [LATCH_W*BC_W-1:0]   sink_level_out;
  logic [BC_W-1:0]           red_bc, green_bc, blue_bc;
  logic [DET_W-1:0]          detect_code_out;
  logic                      open_chk, short_chk, on_ld, ctl_ld;
  logic [WORD_W-1:0]         shift_word_out;
  int                        error_cnt = 0;
  int                        n_checks = 0;

  led_link_if led_link_if_i ();
  led_sink_host led_sink_host_i (.clock_in, .rst_in, .write_valid_in,
    .write_select_in, .write_data_in, .blank_in, .write_ready_out,
    .link_if(led_link_if_i));
  led_sink_device led_sink_device_i (.clock_in, .rst_in,
    .link_if(led_link_if_i), .sink_outputs_out, .sink_level_out,
    .red_brightness_out(red_bc), .green_brightness_out(green_bc),
    .blue_brightness_out(blue_bc), .detect_code_out,
    .open_led_check_out(open_chk), .shorted_led_check_out(short_chk),
    .onoff_loaded_out(on_ld), .control_loaded_out(ctl_ld),
    .shift_word_out);
  led_link_properties led_link_properties_i (.clock_in, .rst_in,
    .shift_clock(led_link_if_i.shift_clock),
    .serial_data(led_link_if_i.serial_data),
    .transfer_pulse(led_link_if_i.transfer_pulse),
    .blank(led_link_if_i.blank), .sink_outputs_out, .shift_word_out,
    .onoff_loaded_out(on_ld), .control_loaded_out(ctl_ld));

  always #4 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick

  task automatic wait_ready();
    int n;
    n = 0;
    while (write_ready_out !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) check("write ready", 1, write_ready_out);
  endtask : wait_ready

  task automatic start_word(input logic sel, input logic [23:0] d);
    write_select_in = sel;
    write_data_in   = d;
    write_valid_in  = 1'b1;
    wait_ready();
    tick(1);
    write_valid_in = 1'b0;
    tick(1);
  endtask : start_word

  // Device lands the latch three cycles after the pulse rises, before ready returns
  task automatic write(input logic sel, input logic [23:0] d);
    start_word(sel, d);
    wait_ready();
    tick(8);
  endtask : write

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_onoff();
    check("sinks at start", 0, sink_outputs_out);
    // Zero bits stand for channels with no LED fitted
    write(1'b0, 24'ha5c3e1);
    check("sinks blanked", 0, sink_outputs_out);
    check("word", {1'b0, 24'ha5c3e1}, shift_word_out);
    write(1'b1, {3'h0, 7'h7f, 7'h7f, 7'h7f});
    check("red init", 7'h7f, red_bc);
    check("sinks still blanked", 0, sink_outputs_out);
    blank_in = 1'b0;
    tick(6);
    check("sinks", 24'ha5c3e1, sink_outputs_out);
  endtask : t_onoff

  task automatic t_controls();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      write(1'b1, {c, 7'(i * 9), 7'h55, 7'(i + 1)});
      check("code", c, detect_code_out);
      check("short", c[2], short_chk);
      check("open", !c[2], open_chk);
      check("red", 7'(i + 1), red_bc);
      check("green", 7'h55, green_bc);
      check("blue", 7'(i * 9), blue_bc);
      check("level0", 7'(i + 1), sink_level_out[6:0]);
      check("sinks kept", 24'ha5c3e1, sink_outputs_out);
    end
  endtask : t_controls

  task automatic t_overlap();
    start_word(1'b0, 24'h00ff0f);
    tick(100);
    check("mid shift", 24'ha5c3e1, sink_outputs_out);
    wait_ready();
    tick(8);
    check("new sinks", 24'h00ff0f, sink_outputs_out);
  endtask : t_overlap

  task automatic t_reblank();
    blank_in = 1'b1;
    tick(6);
    check("blank sinks", 0, sink_outputs_out);
    check("blank level", 0, sink_level_out[8*7+:7]);
    blank_in = 1'b0;
    tick(6);
    check("level8", 7'h55, sink_level_out[8*7+:7]);
    check("level4", 0, sink_level_out[4*7+:7]);
  endtask : t_reblank

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    clock_in        = 1'b0;
    rst_in          = 1'b1;
    blank_in        = 1'b1;
    write_valid_in  = 1'b0;
    write_select_in = 1'b0;
    write_data_in   = '0;
    tick(6);
    rst_in = 1'b0;
    tick(2);
    t_onoff();
    t_controls();
    t_overlap();
    t_reblank();
    report_and_stop();
  end

  // Whole run is near 2400 cycles; allow ten times that
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule : test_led_sink_onoff_latch_select
